// File: design/vcsp_top.sv
////////////////////////////////////////////////////////////////////////////////
// Output FIFO with registered head
module vcsp_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic [$clog2(D):0] level_o,
  // Drain side
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  logic push, pop;
  assign in_ready_o = cnt_q != (AW+1)'(D);
  assign push = in_valid_i && in_ready_o;
  assign pop = (cnt_q != '0) && (!out_valid_o || out_ready_i);
  assign level_o = cnt_q;
  always_ff @(posedge ref_clk_i) begin
    if (push) mem[wp_q] <= in_data_i;
  end
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else if (pop) begin
      out_valid_o <= 1'b1;
      out_data_o <= mem[rp_q];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Gain stage, coefficient signed Q3.12
module vcsp_gain (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic byp_i,
  input wire logic [15:0] coef_i,
  input wire logic in_v_i,
  input wire logic signed [15:0] in_d_i,
  output logic out_v_o,
  output logic signed [15:0] out_d_o
);
  import vcsp_pkg::*;
  logic signed [31:0] prod;
  assign prod = (32'(in_d_i) * 32'(signed'(coef_i))) >>> GAIN_FRAC;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_v_o <= 1'b0;
      out_d_o <= '0;
    end else begin
      out_v_o <= in_v_i;
      if (in_v_i) out_d_o <= byp_i ? in_d_i : vcsp_sat(prod);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Frequency correction, six taps of two bytes each, Q2.13
module vcsp_eq (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic byp_i,
  input wire logic [95:0] coef_i,
  input wire logic in_v_i,
  input wire logic signed [15:0] in_d_i,
  output logic out_v_o,
  output logic signed [15:0] out_d_o
);
  import vcsp_pkg::*;
  logic signed [15:0] hist_q [EQ_TAPS-1];
  logic signed [31:0] acc;
  always_comb begin
    acc = 32'(in_d_i) * 32'(signed'(coef_i[95:80]));
    for (int k = 1; k < EQ_TAPS; k++) begin
      acc = acc + 32'(hist_q[k-1]) * 32'(signed'(coef_i[95-16*k -: 16]));
    end
  end
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int k = 0; k < EQ_TAPS-1; k++) hist_q[k] <= '0;
      out_v_o <= 1'b0;
      out_d_o <= '0;
    end else begin
      out_v_o <= in_v_i;
      if (in_v_i) begin
        hist_q[0] <= in_d_i;
        for (int k = 1; k < EQ_TAPS-1; k++) hist_q[k] <= hist_q[k-1];
        out_d_o <= byp_i ? in_d_i : vcsp_sat(acc >>> EQ_FRAC);
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// One-pole low-pass, or high-pass as input minus low-pass
module vcsp_iir #(
  parameter int SHIFT = 1,
  parameter bit HIGH = 1'b0
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic byp_i,
  input wire logic in_v_i,
  input wire logic signed [15:0] in_d_i,
  output logic out_v_o,
  output logic signed [15:0] out_d_o
);
  import vcsp_pkg::*;
  logic signed [15:0] s_q;
  logic signed [16:0] diff;
  logic signed [15:0] s_n;
  assign diff = 17'(in_d_i) - 17'(s_q);
  assign s_n = s_q + 16'(diff >>> SHIFT);
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
      out_v_o <= 1'b0;
      out_d_o <= '0;
    end else begin
      out_v_o <= in_v_i;
      if (in_v_i) begin
        s_q <= s_n;
        if (byp_i) out_d_o <= in_d_i;
        else out_d_o <= HIGH ? vcsp_sat(32'(diff)) : s_n;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Linear interpolator, 2**LOG outputs per input on consecutive cycles
module vcsp_interp #(
  parameter int LOG = 2
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic in_v_i,
  input wire logic signed [15:0] in_d_i,
  output logic out_v_o,
  output logic signed [15:0] out_d_o
);
  import vcsp_pkg::*;
  logic signed [15:0] prev_q, cur_q;
  logic [LOG:0] k_q;
  logic signed [31:0] step;
  // Phase is zero-extended so the product stays signed for falling ramps
  assign step = ((32'(cur_q) - 32'(prev_q)) * 32'($signed({1'b0, k_q}))) >>> LOG;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_q <= '0;
      cur_q <= '0;
      k_q <= '0;
      out_v_o <= 1'b0;
      out_d_o <= '0;
    end else begin
      out_v_o <= k_q != '0;
      if (k_q != '0) out_d_o <= vcsp_sat(32'(prev_q) + step);
      if (in_v_i) begin
        prev_q <= cur_q;
        cur_q <= in_d_i;
        k_q <= (LOG+1)'(1);
      end else if (k_q != '0) begin
        k_q <= (k_q == (LOG+1)'(1 << LOG)) ? '0 : k_q + 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Voice signal processor top
module vcsp_top (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Coefficient RAM write port
  input wire logic coef_we_i,
  input wire logic [vcsp_pkg::CAW-1:0] coef_addr_i,
  input wire logic [7:0] coef_data_i,
  // Configuration
  input wire logic [1:0] voice_data_manip_i,
  input wire logic dtmf_enable_i,
  input wire logic tone_to_transmit_i,
  input wire logic signed [vcsp_pkg::DW-1:0] tone_data_i,
  // Oversampled A/D input
  input wire logic adc_valid_i,
  input wire logic signed [vcsp_pkg::DW-1:0] adc_data_i,
  output logic adc_ready_o,
  // Transmit PCM
  output logic tx_valid_o,
  output logic [vcsp_pkg::DW-1:0] tx_data_o,
  input wire logic tx_ready_i,
  // Receive PCM
  input wire logic rx_valid_i,
  input wire logic [vcsp_pkg::DW-1:0] rx_data_i,
  // Oversampled D/A output
  output logic dac_valid_o,
  output logic signed [vcsp_pkg::DW-1:0] dac_data_o
);
  import vcsp_pkg::*;
  logic [7:0] coefficient_ram_q [COEFFICIENT_RAM_DEPTH];
  logic txg_set_q, rxg_set_q, txeq_set_q, rxeq_set_q;
  logic lin;
  logic [95:0] tx_eq_c, rx_eq_c;
  logic [$clog2(FIFO_DEPTH):0] fifo_lvl;
  logic adc_take;
  logic [DEC_LOG-1:0] dec_cnt_q;
  logic signed [DW+DEC_LOG-1:0] dec_acc_q, dec_sum;
  logic dec_v_q, vlp_v, mix_v_q, dt_v, hpx_v, fx_v, gx_v, enc_v_q;
  logic signed [DW-1:0] dec_d_q, vlp_d, mix_d_q, dt_d, hpx_d, fx_d, gx_d;
  logic [DW-1:0] enc_d_q;
  logic exp_v_q, st_v_q, hpr_v, fr_v, gr_v, rlp_v, itp_v;
  logic signed [DW-1:0] exp_d_q, st_d_q, hpr_d, fr_d, gr_d, rlp_d, itp_d;
  logic side_v;
  logic signed [DW-1:0] side_d;

  assign lin = voice_data_manip_i[1];
  assign adc_take = adc_valid_i && adc_ready_o;
  assign dec_sum = dec_acc_q + (DW+DEC_LOG)'(adc_data_i);
  always_comb begin
    for (int k = 0; k < 12; k++) begin
      tx_eq_c[95-8*k -: 8] = coefficient_ram_q[CA_TX_EQ + 5'(k)];
      rx_eq_c[95-8*k -: 8] = coefficient_ram_q[CA_RX_EQ + 5'(k)];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Coefficient RAM and bypass-release flags
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < COEFFICIENT_RAM_DEPTH; i++) coefficient_ram_q[i] <= 8'h00;
    end else if (coef_we_i && coef_addr_i < 5'(COEFFICIENT_RAM_DEPTH)) begin
      coefficient_ram_q[coef_addr_i] <= coef_data_i;
    end
  end
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      txg_set_q <= 1'b0;
      rxg_set_q <= 1'b0;
      txeq_set_q <= 1'b0;
      rxeq_set_q <= 1'b0;
    end else if (coef_we_i) begin
      if (coef_addr_i[4:1] == CA_TX_GAIN[4:1]) txg_set_q <= 1'b1;
      if (coef_addr_i[4:1] == CA_RX_GAIN[4:1]) rxg_set_q <= 1'b1;
      if (coef_addr_i >= CA_TX_EQ && coef_addr_i < CA_TX_EQ + EQ_BYTES) txeq_set_q <= 1'b1;
      if (coef_addr_i >= CA_RX_EQ && coef_addr_i < CA_RX_EQ + EQ_BYTES) rxeq_set_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmit: decimation to the PCM rate
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dec_cnt_q <= '0;
      dec_acc_q <= '0;
      dec_v_q <= 1'b0;
      dec_d_q <= '0;
    end else begin
      dec_v_q <= adc_take && dec_cnt_q == DEC_LOG'(DEC_RATIO-1);
      if (adc_take) begin
        dec_cnt_q <= dec_cnt_q + 1'b1;
        dec_acc_q <= (dec_cnt_q == DEC_LOG'(DEC_RATIO-1)) ? '0 : dec_sum;
        if (dec_cnt_q == DEC_LOG'(DEC_RATIO-1)) dec_d_q <= DW'(dec_sum >>> DEC_LOG);
      end
    end
  end
  // Voice-band low-pass at the end of decimation
  vcsp_iir #(.SHIFT(VOICE_LP_SHIFT), .HIGH(1'b0)) u_vlp (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .byp_i(1'b0),
    .in_v_i(dec_v_q), .in_d_i(dec_d_q), .out_v_o(vlp_v), .out_d_o(vlp_d));
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mix_v_q <= 1'b0;
      mix_d_q <= '0;
    end else begin
      mix_v_q <= vlp_v;
      if (vlp_v) begin
        mix_d_q <= tone_to_transmit_i ? vcsp_sat(32'(vlp_d) + 32'(tone_data_i)) : vlp_d;
      end
    end
  end
  vcsp_iir #(.SHIFT(DTMF_LP_SHIFT), .HIGH(1'b0)) u_dtmf_lp (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .byp_i(!dtmf_enable_i),
    .in_v_i(mix_v_q), .in_d_i(mix_d_q), .out_v_o(dt_v), .out_d_o(dt_d));
  vcsp_iir #(.SHIFT(HP_SHIFT), .HIGH(1'b1)) u_transmit_highpass (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .byp_i(1'b0),
    .in_v_i(dt_v), .in_d_i(dt_d), .out_v_o(hpx_v), .out_d_o(hpx_d));
  vcsp_eq u_transmit_eq_filter (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .byp_i(!txeq_set_q), .coef_i(tx_eq_c),
    .in_v_i(hpx_v), .in_d_i(hpx_d), .out_v_o(fx_v), .out_d_o(fx_d));
  vcsp_gain u_transmit_gain (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .byp_i(!txg_set_q),
    .coef_i({coefficient_ram_q[CA_TX_GAIN], coefficient_ram_q[CA_TX_GAIN+5'h01]}),
    .in_v_i(fx_v), .in_d_i(fx_d), .out_v_o(gx_v), .out_d_o(gx_d));
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      enc_v_q <= 1'b0;
      enc_d_q <= '0;
    end else begin
      enc_v_q <= gx_v;
      if (gx_v) begin
        if (lin) enc_d_q <= gx_d;
        else if (voice_data_manip_i == VDM_MULAW) enc_d_q <= {8'h00, vcsp_mu_enc(gx_d)};
        else enc_d_q <= {8'h00, vcsp_a_enc(gx_d)};
      end
    end
  end
  vcsp_fifo #(.W(DW), .D(FIFO_DEPTH)) u_tx_fifo (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .in_valid_i(enc_v_q), .in_data_i(enc_d_q), .in_ready_o(), .level_o(fifo_lvl),
    .out_valid_o(tx_valid_o), .out_data_o(tx_data_o), .out_ready_i(tx_ready_i));
  // Stall the converter early enough that in-flight samples still fit
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) adc_ready_o <= 1'b0;
    else adc_ready_o <= fifo_lvl <= ($clog2(FIFO_DEPTH)+1)'(FIFO_DEPTH - READY_MARGIN);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive path
  vcsp_gain u_sidetone_gain (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .byp_i(1'b0),
    .coef_i({coefficient_ram_q[CA_SIDE_GAIN], coefficient_ram_q[CA_SIDE_GAIN+5'h01]}),
    .in_v_i(gx_v), .in_d_i(gx_d), .out_v_o(side_v), .out_d_o(side_d));
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      exp_v_q <= 1'b0;
      exp_d_q <= '0;
      st_v_q <= 1'b0;
      st_d_q <= '0;
    end else begin
      exp_v_q <= rx_valid_i;
      if (rx_valid_i) begin
        if (lin) exp_d_q <= rx_data_i;
        else if (voice_data_manip_i == VDM_MULAW) exp_d_q <= vcsp_mu_dec(rx_data_i[7:0]);
        else exp_d_q <= vcsp_a_dec(rx_data_i[7:0]);
      end
      st_v_q <= exp_v_q;
      if (exp_v_q) st_d_q <= vcsp_sat(32'(exp_d_q) + 32'(side_d));
    end
  end
  vcsp_iir #(.SHIFT(HP_SHIFT), .HIGH(1'b1)) u_receive_highpass (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .byp_i(1'b0),
    .in_v_i(st_v_q), .in_d_i(st_d_q), .out_v_o(hpr_v), .out_d_o(hpr_d));
  vcsp_eq u_receive_eq_filter (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .byp_i(!rxeq_set_q), .coef_i(rx_eq_c),
    .in_v_i(hpr_v), .in_d_i(hpr_d), .out_v_o(fr_v), .out_d_o(fr_d));
  vcsp_gain u_receive_gain (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .byp_i(!rxg_set_q),
    .coef_i({coefficient_ram_q[CA_RX_GAIN], coefficient_ram_q[CA_RX_GAIN+5'h01]}),
    .in_v_i(fr_v), .in_d_i(fr_d), .out_v_o(gr_v), .out_d_o(gr_d));
  vcsp_iir #(.SHIFT(VOICE_LP_SHIFT), .HIGH(1'b0)) u_rx_lp (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .byp_i(1'b0),
    .in_v_i(gr_v), .in_d_i(gr_d), .out_v_o(rlp_v), .out_d_o(rlp_d));
  vcsp_interp #(.LOG(INT_LOG)) u_interp (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .in_v_i(rlp_v), .in_d_i(rlp_d), .out_v_o(itp_v), .out_d_o(itp_d));
  vcsp_iir #(.SHIFT(DAC_LP_SHIFT), .HIGH(1'b0)) u_dac_lp (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .byp_i(1'b0),
    .in_v_i(itp_v), .in_d_i(itp_d), .out_v_o(dac_valid_o), .out_d_o(dac_data_o));

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_last_take;
    adc_take && dec_cnt_q == DEC_LOG'(DEC_RATIO-1);
  endsequence
  sequence s_rx_in;
    rx_valid_i && lin;
  endsequence
  a_lin_tx_out: assert property (gx_v && lin |=> enc_v_q && enc_d_q == $past(gx_d))
    else $error("linear transmit word altered");
  a_law_tx_width: assert property (gx_v && !lin |=> enc_v_q && enc_d_q[15:8] == 8'h00)
    else $error("companded code wider than 8 bits");
  a_rx_lin_pass: assert property (s_rx_in |=> exp_v_q && exp_d_q == $past(rx_data_i))
    else $error("linear receive word altered");
  a_decim_rate: assert property (s_last_take |=> dec_v_q ##1 vlp_v)
    else $error("decimated sample missing");
  a_decim_only: assert property (dec_v_q |-> $past(adc_take) && $past(dec_cnt_q) == 2'h3)
    else $error("decimated sample at wrong phase");
  a_dtmf_bypass: assert property (mix_v_q && !dtmf_enable_i |=> dt_v && dt_d == $past(mix_d_q))
    else $error("DTMF filter active while disabled");
  a_tone_mix_off: assert property (vlp_v && !tone_to_transmit_i |=> mix_d_q == $past(vlp_d))
    else $error("tone mixed while switched off");
  a_tx_gain_byp: assert property (fx_v && !txg_set_q |=> gx_v && gx_d == $past(fx_d))
    else $error("transmit gain not bypassed");
  a_tx_eq_byp: assert property (hpx_v && !txeq_set_q |=> fx_v && fx_d == $past(hpx_d))
    else $error("transmit correction not bypassed");
  a_rx_gain_byp: assert property (fr_v && !rxg_set_q |=> gr_v && gr_d == $past(fr_d))
    else $error("receive gain not bypassed");
  a_sidetone_off: assert property (exp_v_q && side_d == 16'sh0000 |=> st_d_q == $past(exp_d_q))
    else $error("sidetone added while muted");
  a_interp_burst: assert property (rlp_v |=> ##1 itp_v [*4])
    else $error("interpolator burst short");
endmodule

// File: design/vcsp_pkg.sv
// Overview of operation
// - Transmit emits 8-bit companded or 16-bit linear
// - Voice/data manipulation bits select compander bypass
// - Receive expands codes; linear input bypasses expander
// - Transmit decimates to 8 kHz, voice low-pass
// - DTMF enable inserts 2 kHz transmit low-pass
// - Tone-to-transmit set adds tone to transmit
// - Transmit gain uses two-byte coefficient, fine steps
// - Transmit gain bypassed after reset until written
// - Transmit correction: twelve bytes, bypassed after reset
// - Sidetone adds scaled signal, off after reset
// - Receive correction matches transmit, bypassed after reset
// - Receive gain two-byte coefficient, bypassed after reset
// - High-pass filters in both directions
// - Interpolator raises rate, DAC low-pass after it drives converter
package vcsp_pkg;
  localparam int DW = 16;
  localparam int CAW = 5;
  localparam int COEFFICIENT_RAM_DEPTH = 30;
  localparam logic [4:0] CA_TX_GAIN = 5'h00;
  localparam logic [4:0] CA_RX_GAIN = 5'h02;
  localparam logic [4:0] CA_SIDE_GAIN = 5'h04;
  localparam logic [4:0] CA_TX_EQ = 5'h06;
  localparam logic [4:0] CA_RX_EQ = 5'h12;
  localparam logic [4:0] EQ_BYTES = 5'h0c;
  localparam int EQ_TAPS = 6;
  localparam int GAIN_FRAC = 12;
  localparam int EQ_FRAC = 13;
  localparam int DEC_RATIO = 4;
  localparam int DEC_LOG = 2;
  localparam int INT_LOG = 2;
  localparam int VOICE_LP_SHIFT = 1;
  localparam int DTMF_LP_SHIFT = 1;
  localparam int HP_SHIFT = 6;
  localparam int DAC_LP_SHIFT = 1;
  localparam int FIFO_DEPTH = 16;
  localparam int READY_MARGIN = 4;
  localparam logic [1:0] VDM_ALAW = 2'h0;
  localparam logic [1:0] VDM_MULAW = 2'h1;

  function automatic logic signed [15:0] vcsp_sat(input logic signed [31:0] v);
    if (v > 32'sd32767) return 16'sh7fff;
    if (v < -32'sd32768) return 16'sh8000;
    return v[15:0];
  endfunction

  function automatic logic [7:0] vcsp_mu_enc(input logic signed [15:0] x);
    logic [15:0] m;
    logic [2:0] seg;
    m = x[15] ? 16'(-x) : 16'(x);
    m = m >> 2;
    if (m > 16'd8158) m = 16'd8158;
    m = m + 16'd33;
    seg = 3'h0;
    for (int i = 0; i < 8; i++) if (m[i+5]) seg = 3'(i);
    m = m >> ({1'b0, seg} + 4'h1);
    return ~{x[15], seg, m[3:0]};
  endfunction

  function automatic logic signed [15:0] vcsp_mu_dec(input logic [7:0] c);
    logic [7:0] u;
    logic [15:0] t;
    u = ~c;
    t = (({12'h000, u[3:0]} << 3) + 16'h0084) << u[6:4];
    t = t - 16'h0084;
    return u[7] ? 16'(-t) : 16'(t);
  endfunction

  function automatic logic [7:0] vcsp_a_enc(input logic signed [15:0] x);
    logic [15:0] m;
    logic [2:0] seg;
    m = x[15] ? 16'(-x) : 16'(x);
    m = m >> 3;
    if (m > 16'd4095) m = 16'd4095;
    seg = 3'h0;
    for (int i = 1; i < 8; i++) if (m[i+4]) seg = 3'(i);
    m = (seg < 3'h2) ? (m >> 1) : (m >> seg);
    return {~x[15], seg, m[3:0]} ^ 8'h55;
  endfunction

  function automatic logic signed [15:0] vcsp_a_dec(input logic [7:0] c);
    logic [7:0] u;
    logic [15:0] t;
    u = c ^ 8'h55;
    t = {8'h00, u[3:0], 4'h8};
    if (u[6:4] != 3'h0) t = (t + 16'h0100) << (u[6:4] - 3'h1);
    return u[7] ? 16'(t) : 16'(-t);
  endfunction
endpackage

// File: tb/vcsp_far_model.sv
////////////////////////////////////////
// Converters and PCM port on the far side of the processor
module vcsp_far_model (
  // Clock and bench control
  input wire logic ref_clk_i,
  input wire logic run_i,
  input wire logic rand_i,
  input wire logic stall_i,
  // Converter side
  output logic adc_valid_o = 1'b0,
  output logic [15:0] adc_data_o = 16'h0000,
  input wire logic adc_ready_i,
  // PCM side
  input wire logic tx_valid_i,
  input wire logic [15:0] tx_data_i,
  output logic tx_ready_o = 1'b0,
  output logic rx_valid_o = 1'b0,
  output logic [15:0] rx_data_o = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] txq[$];

  // Sample held until taken; idle data toggles so it is never stale
  always @(posedge ref_clk_i) begin
    if (!adc_valid_o || adc_ready_i) begin
      adc_valid_o <= run_i;
      adc_data_o <= !run_i ? ~adc_data_o : rand_i ? 16'($urandom) : 16'h0000;
    end
    tx_ready_o <= !stall_i;
    if (tx_valid_i && tx_ready_o) txq.push_back(tx_data_i);
  end

  // One full word per pulse, released data inverted
  task automatic send_rx(input logic [15:0] d);
    @(posedge ref_clk_i);
    rx_valid_o <= 1'b1;
    rx_data_o <= d;
    @(posedge ref_clk_i);
    rx_valid_o <= 1'b0;
    rx_data_o <= ~d;
  endtask
endmodule

// File: tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import vcsp_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic coef_we_i = 1'b0;
  logic [CAW-1:0] coef_addr_i = 5'h00;
  logic [7:0] coef_data_i = 8'h00;
  logic [1:0] voice_data_manip_i = 2'h2;
  logic dtmf_enable_i = 1'b0;
  logic tone_to_transmit_i = 1'b0;
  logic signed [DW-1:0] tone_data_i = 16'sh1000;
  logic adc_valid_i, adc_ready_o, tx_valid_o, tx_ready_i, rx_valid_i, dac_valid_o;
  logic [DW-1:0] adc_data_i, tx_data_o, rx_data_i, dac_data_o;
  logic run = 1'b0;
  logic rnd = 1'b0;
  logic stall = 1'b0;
  logic nz;
  logic [15:0] w0, w1, wp;
  int fails = 0;
  int num_checks = 0;
  int k, n;

  vcsp_top dut (.ref_clk_i, .rst_i, .coef_we_i, .coef_addr_i, .coef_data_i,
    .voice_data_manip_i, .dtmf_enable_i, .tone_to_transmit_i, .tone_data_i, .adc_valid_i,
    .adc_data_i, .adc_ready_o, .tx_valid_o, .tx_data_o, .tx_ready_i, .rx_valid_i,
    .rx_data_i, .dac_valid_o, .dac_data_o);
  vcsp_far_model far (.ref_clk_i, .run_i(run), .rand_i(rnd), .stall_i(stall),
    .adc_valid_o(adc_valid_i), .adc_data_o(adc_data_i), .adc_ready_i(adc_ready_o),
    .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i),
    .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i));

  initial begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  ////////////////////////////////////////
  task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_nz(input string nm, input logic [15:0] g);
    num_checks++;
    if (g === 16'h0000 || $isunknown(g)) begin
      fails++;
      $display("Error %s expected nonzero seen %h", nm, g);
    end
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Idle transmit word for each coding mode
  function automatic logic [15:0] exp_idle(input logic [1:0] m);
    if (m == VDM_ALAW) return 16'h00d5;
    if (m == VDM_MULAW) return 16'h00ff;
    return 16'h0000;
  endfunction

  // Random data is chosen a cycle ahead so no stale sample survives reset
  task automatic restart(input logic [1:0] m, input logic t, input logic d, input logic r);
    @(posedge ref_clk_i);
    rnd <= r;
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    voice_data_manip_i <= m;
    tone_to_transmit_i <= t;
    dtmf_enable_i <= d;
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task automatic wr_coef(input int base, input int cnt, input logic [15:0] v);
    for (int i = 0; i < cnt; i++) begin
      @(posedge ref_clk_i);
      coef_we_i <= 1'b1;
      coef_addr_i <= CAW'(base + i);
      coef_data_i <= i[0] ? v[7:0] : v[15:8];
    end
    @(posedge ref_clk_i);
    coef_we_i <= 1'b0;
  endtask

  task automatic get_tx(input int cnt);
    @(negedge ref_clk_i);
    far.txq.delete();
    for (k = 0; k < 2000 && far.txq.size() < cnt; k++) @(posedge ref_clk_i);
    if (far.txq.size() < cnt) begin
      fails++;
      $display("Error tx words expected %0d seen %0d", cnt, far.txq.size());
      summarize();
    end
    w0 = far.txq[0];
    w1 = far.txq[$];
  endtask

  task automatic tone_start(input logic d);
    restart(2'h2, 1'b1, d, 1'b0);
    wr_coef(30, 2, 16'($urandom));
    get_tx(2);
  endtask

  task automatic rx_burst(input logic [15:0] d);
    far.send_rx(d);
    nz = 1'b0;
    n = 0;
    while (n < 20 && dac_valid_o !== 1'b1) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk_val("dac latency", 16'd9, 16'(n));
    for (k = 0; k < 5; k++) begin
      chk_val("dac pulse", 16'(k < 4), 16'(dac_valid_o));
      if (k < 4) nz = nz | (dac_data_o !== 16'h0000);
      @(negedge ref_clk_i);
    end
  endtask

  ////////////////////////////////////////
  initial begin
    void'($urandom(32'hedea49c0));
    run <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      restart(2'(m), 1'b0, 1'b0, 1'b0);
      get_tx(3);
      chk_val("tx idle word", exp_idle(2'(m)), w1);
    end
    restart(VDM_MULAW, 1'b0, 1'b0, 1'b1);
    get_tx(4);
    chk_val("tx code high byte", 16'h0000, {8'h00, w1[15:8]});
    for (int s = 0; s < 2; s++) begin
      tone_start(1'b0);
      chk_nz("tx tone word", w0);
      if (s == 0) wp = w0;
      get_tx(200);
      chk_val("tx word rate", 16'h0001, 16'(k >= 796 && k <= 800));
      chk_val("tx decay", 16'h0001, 16'($signed(w1) < $signed(w0) / 2));
      rnd <= 1'b1;
      wr_coef(s ? 6 : 0, s ? 12 : 2, 16'h0000);
      get_tx(6);
      chk_val("tx muted word", 16'h0000, w1);
    end
    tone_start(1'b1);
    chk_nz("tx dtmf change", w0 ^ wp);
    // Stall the consumer until the input is refused, then drain
    restart(2'h2, 1'b0, 1'b0, 1'b1);
    stall <= 1'b1;
    for (k = 0; k < 500 && (k < 4 || adc_ready_o !== 1'b0); k++) @(negedge ref_clk_i);
    chk_val("adc refused", 16'h0000, 16'(adc_ready_o));
    chk_val("tx held", 16'h0001, 16'(tx_valid_o));
    repeat (40) @(posedge ref_clk_i);
    run <= 1'b0;
    stall <= 1'b0;
    far.txq.delete();
    repeat (80) @(posedge ref_clk_i);
    chk_val("drained words", 16'h0001, 16'(far.txq.size() > FIFO_DEPTH - READY_MARGIN));
    chk_val("drained empty", 16'h0000, 16'(tx_valid_o));
    run <= 1'b1;
    restart(VDM_MULAW, 1'b0, 1'b0, 1'b0);
    rx_burst(16'h00ff);
    rx_burst(16'h00ff);
    chk_val("mu-law silence", 16'h0000, 16'(nz));
    // Large negative A-law code: expansion and a falling interpolation ramp
    restart(VDM_ALAW, 1'b0, 1'b0, 1'b0);
    rx_burst(16'h0025);
    chk_val("a-law receive", 16'h0001, 16'(nz));
    chk_val("a-law sign", 16'h0001, 16'(dac_data_o[15]));
    restart(2'h2, 1'b0, 1'b0, 1'b0);
    rx_burst({2'b01, 14'($urandom)});
    chk_val("linear receive", 16'h0001, 16'(nz));
    for (int s = 0; s < 3; s++) begin
      restart(2'h2, 1'b1, 1'b0, 1'b0);
      get_tx(2);
      if (s == 0) begin
        rx_burst(16'h0000);
        chk_val("sidetone off", 16'h0000, 16'(nz));
      end else begin
        wr_coef(s == 1 ? 2 : 18, s == 1 ? 2 : 12, 16'h0000);
      end
      wr_coef(4, 2, 16'h1000);
      rx_burst(16'h0000);
      rx_burst(16'h0000);
      chk_val("sidetone path", 16'(s == 0), 16'(nz));
    end
    summarize();
  end
endmodule
